// File: core/daip_pkg.sv
/*
  Constants for the stereo serial audio input port: control word layout,
  register offsets, field positions, reset values and encodings.
  Assumes a control block that delivers complete 7-bit address and
  9-bit data writes on the core clock.
*/
package daip_pkg;
  // Control word layout
  localparam int ADDR_W = 7;
  localparam int DATA_W = 9;
  localparam int SAMPLE_W = 32;

  // Register offsets
  localparam logic [6:0] FMT_CTRL_ADDR = 7'h05;
  localparam logic [6:0] MODE_CTRL_ADDR = 7'h07;
  localparam logic [6:0] CHAIN_CTRL_ADDR = 7'h08;

  // Format control fields
  localparam int WL_LSB = 0;
  localparam int FMT_LSB = 2;
  localparam int POL_BIT = 4;
  localparam int EDGE_BIT = 5;
  // Mode control fields
  localparam int PATH_LSB = 0;
  localparam int RATIO_LSB = 2;
  localparam int EIGHT_BIT = 7;
  // Chain control field
  localparam int CHAIN_EN_BIT = 4;

  // Values after reset
  localparam logic [8:0] FMT_CTRL_RST = 9'h00a;
  localparam logic [8:0] MODE_CTRL_RST = 9'h000;
  localparam logic [8:0] CHAIN_CTRL_RST = 9'h000;

  // Framing encodings
  localparam logic [1:0] FMT_RJ = 2'h0;
  localparam logic [1:0] FMT_LJ = 2'h1;
  localparam logic [1:0] FMT_I2S = 2'h2;
  localparam logic [1:0] FMT_DSP = 2'h3;
  // Word length encodings
  localparam logic [1:0] WL_16 = 2'h0;
  localparam logic [1:0] WL_20 = 2'h1;
  localparam logic [1:0] WL_24 = 2'h2;
  localparam logic [1:0] WL_32 = 2'h3;
  // Path encodings
  localparam logic [1:0] PATH_PCM = 2'h0;
  localparam logic [1:0] PATH_DIRECT = 2'h1;
  localparam logic [1:0] PATH_FILT = 2'h2;

  // Frame period that forces 16-bit words, in bit clocks
  localparam logic [7:0] SHORT_FRAME_BCLKS = 8'h20;
  // Counter value of the last bit packed in a bitstream word
  localparam logic [4:0] BS_LAST_BIT = 5'h1f;

  // Ratio codes and classification bounds in core cycles per frame
  localparam logic [2:0] RATIO_NONE = 3'h0;
  localparam logic [2:0] RATIO_128 = 3'h1;
  localparam logic [2:0] RATIO_192 = 3'h2;
  localparam logic [2:0] RATIO_256 = 3'h3;
  localparam logic [2:0] RATIO_384 = 3'h4;
  localparam logic [2:0] RATIO_512 = 3'h5;
  localparam logic [2:0] RATIO_768 = 3'h6;
  localparam logic [11:0] RATIO_MIN = 12'h060;
  localparam logic [11:0] RATIO_B192 = 12'h0a0;
  localparam logic [11:0] RATIO_B256 = 12'h0e0;
  localparam logic [11:0] RATIO_B384 = 12'h140;
  localparam logic [11:0] RATIO_B512 = 12'h1c0;
  localparam logic [11:0] RATIO_B768 = 12'h280;
  localparam logic [11:0] RATIO_MAX = 12'h380;
endpackage

// File: core/daip_core.sv
/*
  Serial audio input port: PCM framings, 8x-rate split pins, two-channel
  bitstream input, chained data output in DSP framing and frame ratio detection.
  Assumes the source drives frame clock and data in the bit clock
  domain, and that the bit clock edge select and path are changed
  only while the bit clock is stopped or the output is muted.
*/
`timescale 1ns/10ps
`default_nettype none

module daip_core (
  input wire logic core_clk_in,
  input wire logic rst_b_in,
  input wire logic bit_clk_in,
  input wire logic frame_clk_in,
  input wire logic serial_data_in,
  input wire logic left_fast_data_in,
  input wire logic right_fast_data_in,
  input wire logic left_bitstream_in,
  input wire logic right_bitstream_in,
  input wire logic reg_wr_in,
  input wire logic [daip_pkg::ADDR_W-1:0] reg_addr_in,
  input wire logic [daip_pkg::DATA_W-1:0] reg_data_in,
  output logic [daip_pkg::SAMPLE_W-1:0] left_sample_out,
  output logic left_valid_out,
  output logic [daip_pkg::SAMPLE_W-1:0] right_sample_out,
  output logic right_valid_out,
  output logic filter_bypass_out,
  output logic chain_data_out,
  output logic [2:0] ratio_code_out,
  output logic short_frame_out
);
  import daip_pkg::*;

  // Word length in bits for a length code
  function automatic logic [5:0] wl_bits(input logic [1:0] code);
    case (code)
      WL_16: wl_bits = 6'h10;
      WL_20: wl_bits = 6'h14;
      WL_24: wl_bits = 6'h18;
      default: wl_bits = 6'h20;
    endcase
  endfunction

  // Left-align the newest wl bits of a shift register at bit 31
  function automatic logic [31:0] align(input logic [31:0] sh,
                                        input logic [5:0] wl);
    align = sh << (6'h20 - wl);
  endfunction

  // Core domain register file
  logic [8:0] fmt_ctrl_r, mode_ctrl_r, chain_ctrl_r;

  // Control writes; unknown addresses are ignored
  always_ff @(posedge core_clk_in)
  begin
    if (!rst_b_in)
    begin
      fmt_ctrl_r <= FMT_CTRL_RST;
      mode_ctrl_r <= MODE_CTRL_RST;
      chain_ctrl_r <= CHAIN_CTRL_RST;
    end
    else if (reg_wr_in)
    begin
      if (reg_addr_in == FMT_CTRL_ADDR)
        fmt_ctrl_r <= reg_data_in;
      if (reg_addr_in == MODE_CTRL_ADDR)
        mode_ctrl_r <= reg_data_in;
      if (reg_addr_in == CHAIN_CTRL_ADDR)
        chain_ctrl_r <= reg_data_in;
    end
  end

  // Capture edge: PCM rising by default, bitstream falling by default
  logic bs_core, link_inv, link_clk;
  assign bs_core = (mode_ctrl_r[PATH_LSB+:2] == PATH_DIRECT) ||
                   (mode_ctrl_r[PATH_LSB+:2] == PATH_FILT);
  assign link_inv = fmt_ctrl_r[EDGE_BIT] ^ bs_core;
  // Inverting the clock keeps one domain instead of two edge paths
  assign link_clk = bit_clk_in ^ link_inv;

  // Link domain reset and configuration crossing (quasi-static levels)
  logic [1:0] lrst_sync_r;
  logic [9:0] cfg_meta_r, cfg_l_r, cfg_core;
  logic lrst_b;
  assign cfg_core = {chain_ctrl_r[CHAIN_EN_BIT], mode_ctrl_r[EIGHT_BIT],
                     mode_ctrl_r[PATH_LSB+:2], fmt_ctrl_r[POL_BIT],
                     fmt_ctrl_r[FMT_LSB+:2], fmt_ctrl_r[WL_LSB+:2], 1'b0};
  assign lrst_b = lrst_sync_r[1];

  always_ff @(posedge link_clk)
  begin
    lrst_sync_r <= {lrst_sync_r[0], rst_b_in};
    cfg_meta_r <= cfg_core;
    cfg_l_r <= cfg_meta_r;
  end

  // Decoded link configuration
  logic [1:0] l_wl_sel, l_fmt, l_path;
  logic l_pol, l_eight, l_chain, l_dsp, l_pcm, l_fast;
  assign l_wl_sel = cfg_l_r[2:1];
  assign l_fmt = cfg_l_r[4:3];
  assign l_pol = cfg_l_r[5];
  assign l_path = cfg_l_r[7:6];
  assign l_eight = cfg_l_r[8];
  assign l_chain = cfg_l_r[9];
  assign l_pcm = (l_path == PATH_PCM) && !l_eight;
  assign l_fast = (l_path == PATH_PCM) && l_eight;
  assign l_dsp = l_fmt == FMT_DSP;

  // Frame level; in DSP the polarity bit picks A or B instead
  logic lvl, fr_prev_r, rise, fall;
  assign lvl = frame_clk_in ^ (l_pol && !(l_dsp && l_pcm));
  assign rise = lvl && !fr_prev_r;
  assign fall = !lvl && fr_prev_r;

  // Effective word length: 16 forced, 8x mode limited to 20/24
  logic force16_r;
  logic [5:0] wl;
  always_comb
  begin
    if (l_fast)
      wl = (l_wl_sel == WL_16 || l_wl_sel == WL_20) ? 6'h14 : 6'h18;
    else if (force16_r)
      wl = 6'h10;
    else
      wl = wl_bits(l_wl_sel);
  end

  // Edge index since the word's reference frame edge
  logic restart;
  logic [7:0] bit_cnt_r, n, off;
  always_comb
  begin
    if (l_fast)
      restart = (l_fmt == FMT_LJ) ? fall : rise;
    else if (l_dsp)
      restart = rise;
    else
      restart = rise || fall;
    n = restart ? 8'h00 : bit_cnt_r + 8'h01;
    // I2S and DSP A lag the reference by one edge
    off = (l_fmt == FMT_I2S || (l_dsp && !l_pol)) ? 8'h01 : 8'h00;
  end

  // Frame tracking, counters and shift registers
  logic [7:0] per_r;
  logic [4:0] bs_cnt_r;
  logic [31:0] sh_r, shl_r, shr_r, sh_nxt, shl_nxt, shr_nxt;
  logic l_bit, r_bit;
  assign l_bit = l_pcm || l_fast ? left_fast_data_in : left_bitstream_in;
  assign r_bit = l_pcm || l_fast ? right_fast_data_in : right_bitstream_in;
  assign sh_nxt = {sh_r[30:0], serial_data_in};
  assign shl_nxt = {shl_r[30:0], l_bit};
  assign shr_nxt = {shr_r[30:0], r_bit};

  always_ff @(posedge link_clk)
  begin
    fr_prev_r <= lvl;
    sh_r <= sh_nxt;
    shl_r <= shl_nxt;
    shr_r <= shr_nxt;
    bs_cnt_r <= lrst_b ? bs_cnt_r + 5'h01 : 5'h00;
    if (!lrst_b)
      bit_cnt_r <= 8'hff;
    else if (n != 8'hff)
      bit_cnt_r <= n;
  end

  // Frame period check for the short-frame override
  always_ff @(posedge link_clk)
  begin
    if (!lrst_b)
    begin
      per_r <= 8'hff;
      force16_r <= 1'b0;
    end
    else if (rise)
    begin
      per_r <= 8'h00;
      if (l_pcm)
        force16_r <= (per_r + 8'h01) == SHORT_FRAME_BCLKS;
    end
    else if (per_r != 8'hff)
      per_r <= per_r + 8'h01;
  end

  // Word completion decode per mode
  logic emit_l, emit_r;
  logic [31:0] word_l, word_r;
  always_comb
  begin
    emit_l = 1'b0;
    emit_r = 1'b0;
    word_l = align(sh_nxt, wl);
    word_r = align(sh_nxt, wl);
    if (!l_pcm && !l_fast)
    begin
      // Bitstream: 32 one-bit samples packed per channel word
      emit_l = bs_cnt_r == BS_LAST_BIT;
      emit_r = emit_l;
      word_l = shl_nxt;
      word_r = shr_nxt;
    end
    else if (l_fast)
    begin
      word_l = align(l_fmt == FMT_LJ ? shl_nxt : shl_r, wl);
      word_r = align(l_fmt == FMT_LJ ? shr_nxt : shr_r, wl);
      if (l_fmt == FMT_LJ)
        emit_l = n == {2'b00, wl} - 8'h01;
      else
        emit_l = rise;
      emit_r = emit_l;
    end
    else if (l_dsp)
    begin
      emit_l = n == off + {2'b00, wl} - 8'h01;
      emit_r = n == off + {1'b0, wl, 1'b0} - 8'h01;
    end
    else if (l_fmt == FMT_RJ)
    begin
      // LSB came on the edge before this transition
      word_l = align(sh_r, wl);
      word_r = word_l;
      emit_l = restart && fr_prev_r;
      emit_r = restart && !fr_prev_r;
    end
    else
    begin
      // I2S carries left while the level is low
      emit_l = (n == off + {2'b00, wl} - 8'h01) &&
               (lvl ^ (l_fmt == FMT_I2S));
      emit_r = (n == off + {2'b00, wl} - 8'h01) &&
               !(lvl ^ (l_fmt == FMT_I2S));
    end
  end

  // Held words plus toggles; words stay stable a whole word period
  logic [31:0] lw_r, rw_r;
  logic ltog_r, rtog_r, ftog_r;
  always_ff @(posedge link_clk)
  begin
    if (!lrst_b)
    begin
      lw_r <= 32'h0000_0000;
      rw_r <= 32'h0000_0000;
      ltog_r <= 1'b0;
      rtog_r <= 1'b0;
      ftog_r <= 1'b0;
    end
    else
    begin
      if (emit_l)
      begin
        lw_r <= word_l;
        ltog_r <= !ltog_r;
      end
      if (emit_r)
      begin
        rw_r <= word_r;
        rtog_r <= !rtog_r;
      end
      if (rise && !(l_pcm && l_dsp && !l_eight) || (rise && l_dsp))
        ftog_r <= !ftog_r;
    end
  end

  // Chain output: serial data delayed by two word lengths
  logic [63:0] dly_r;
  logic [5:0] tap;
  assign tap = 6'(({1'b0, wl} << 1) - 7'h01);
  always_ff @(posedge link_clk)
  begin
    dly_r <= {dly_r[62:0], serial_data_in};
    if (!lrst_b)
      chain_data_out <= 1'b0;
    else
      chain_data_out <= l_chain && l_pcm && l_dsp && dly_r[tap];
  end

  // Event and level crossings into the core domain
  logic [2:0] lsync_r, rsync_r, fsync_r;
  logic [1:0] f16_sync_r;
  always_ff @(posedge core_clk_in)
  begin
    if (!rst_b_in)
    begin
      lsync_r <= 3'h0;
      rsync_r <= 3'h0;
      fsync_r <= 3'h0;
      f16_sync_r <= 2'h0;
    end
    else
    begin
      lsync_r <= {lsync_r[1:0], ltog_r};
      rsync_r <= {rsync_r[1:0], rtog_r};
      fsync_r <= {fsync_r[1:0], ftog_r};
      f16_sync_r <= {f16_sync_r[0], force16_r};
    end
  end

  // Sample hand-over; held words are stable when the toggle arrives
  always_ff @(posedge core_clk_in)
  begin
    if (!rst_b_in)
    begin
      left_sample_out <= 32'h0000_0000;
      right_sample_out <= 32'h0000_0000;
      left_valid_out <= 1'b0;
      right_valid_out <= 1'b0;
    end
    else
    begin
      left_valid_out <= lsync_r[2] != lsync_r[1];
      right_valid_out <= rsync_r[2] != rsync_r[1];
      if (lsync_r[2] != lsync_r[1])
        left_sample_out <= lw_r;
      if (rsync_r[2] != rsync_r[1])
        right_sample_out <= rw_r;
    end
  end

  // Status levels
  always_ff @(posedge core_clk_in)
  begin
    if (!rst_b_in)
    begin
      short_frame_out <= 1'b0;
      filter_bypass_out <= 1'b0;
    end
    else
    begin
      short_frame_out <= f16_sync_r[1];
      filter_bypass_out <= mode_ctrl_r[EIGHT_BIT] ||
                           mode_ctrl_r[PATH_LSB+:2] == PATH_DIRECT;
    end
  end

  // Ratio detection: core cycles per frame, nearest standard ratio
  logic [11:0] rat_cnt_r;
  logic [2:0] rat_class;
  always_comb
  begin
    if (rat_cnt_r < RATIO_MIN || rat_cnt_r > RATIO_MAX)
      rat_class = RATIO_NONE;
    else if (rat_cnt_r < RATIO_B192)
      rat_class = RATIO_128;
    else if (rat_cnt_r < RATIO_B256)
      rat_class = RATIO_192;
    else if (rat_cnt_r < RATIO_B384)
      rat_class = RATIO_256;
    else if (rat_cnt_r < RATIO_B512)
      rat_class = RATIO_384;
    else if (rat_cnt_r < RATIO_B768)
      rat_class = RATIO_512;
    else
      rat_class = RATIO_768;
  end

  // Midpoint windows absorb jitter; 8x mode or a nonzero ratio field selects the programmed ratio
  always_ff @(posedge core_clk_in)
  begin
    if (!rst_b_in)
    begin
      rat_cnt_r <= 12'h000;
      ratio_code_out <= RATIO_NONE;
    end
    else
    begin
      if (fsync_r[2] != fsync_r[1])
        rat_cnt_r <= 12'h001;
      else if (rat_cnt_r != 12'hfff)
        rat_cnt_r <= rat_cnt_r + 12'h001;
      if (mode_ctrl_r[EIGHT_BIT] || mode_ctrl_r[RATIO_LSB+:3] != RATIO_NONE)
        ratio_code_out <= mode_ctrl_r[RATIO_LSB+:3];
      else if (fsync_r[2] != fsync_r[1])
        ratio_code_out <= rat_class;
    end
  end
endmodule

`default_nettype wire

// File: dv/daip_core_properties.sv
/*
  Checker for the audio input port, bound to daip_core.
  Assumes all watched ports are sampled on the core clock.
*/
`timescale 1ns/10ps
`default_nettype none
module daip_checker (
  input wire logic core_clk_in,
  input wire logic rst_b_in,
  input wire logic reg_wr_in,
  input wire logic [daip_pkg::ADDR_W-1:0] reg_addr_in,
  input wire logic [daip_pkg::DATA_W-1:0] reg_data_in,
  input wire logic [daip_pkg::SAMPLE_W-1:0] left_sample_out,
  input wire logic left_valid_out,
  input wire logic [daip_pkg::SAMPLE_W-1:0] right_sample_out,
  input wire logic right_valid_out,
  input wire logic filter_bypass_out,
  input wire logic chain_data_out,
  input wire logic [2:0] ratio_code_out,
  input wire logic short_frame_out
);
  import daip_pkg::*;
  logic [8:0] mode_r;
  logic chain_r;
  wire byp_want = mode_r[EIGHT_BIT] || mode_r[1:0] == PATH_DIRECT;
  // Shadow of the mode register
  always_ff @(posedge core_clk_in)
  begin
    if (!rst_b_in)
      mode_r <= MODE_CTRL_RST;
    else if (reg_wr_in && reg_addr_in == MODE_CTRL_ADDR)
      mode_r <= reg_data_in;
  end
  // Shadow of the chain enable
  always_ff @(posedge core_clk_in)
  begin
    if (!rst_b_in)
      chain_r <= 1'b0;
    else if (reg_wr_in && reg_addr_in == CHAIN_CTRL_ADDR)
      chain_r <= reg_data_in[CHAIN_EN_BIT];
  end
  default clocking cb @(posedge core_clk_in);
  endclocking
  default disable iff (!rst_b_in);
  property p_lv;
    left_valid_out |=> !left_valid_out;
  endproperty
  a_lv: assert property (p_lv)
    else $error("left valid too long");
  property p_rv;
    right_valid_out |=> !right_valid_out;
  endproperty
  a_rv: assert property (p_rv)
    else $error("right valid too long");
  property p_lh;
    $changed(left_sample_out) |-> left_valid_out;
  endproperty
  a_lh: assert property (p_lh)
    else $error("left sample moved without valid");
  property p_rh;
    $changed(right_sample_out) |-> right_valid_out;
  endproperty
  a_rh: assert property (p_rh)
    else $error("right sample moved without valid");
  property p_byp_on;
    byp_want [*4] |-> filter_bypass_out;
  endproperty
  a_byp_on: assert property (p_byp_on)
    else $error("bypass missing");
  property p_byp_off;
    !byp_want [*4] |-> !filter_bypass_out;
  endproperty
  a_byp_off: assert property (p_byp_off)
    else $error("bypass unexpected");
  property p_chain;
    !chain_r [*8] |-> !chain_data_out;
  endproperty
  a_chain: assert property (p_chain)
    else $error("chain output active while off");
  property p_rst;
    $rose(rst_b_in) |-> !left_valid_out && !right_valid_out
      && !short_frame_out && ratio_code_out == RATIO_NONE;
  endproperty
  a_rst: assert property (p_rst)
    else $error("outputs not cleared by reset");
  property p_ratio;
    ratio_code_out <= RATIO_768;
  endproperty
  a_ratio: assert property (p_ratio)
    else $error("ratio code out of range");
  // Main scenarios reached
  c_word: cover property (left_valid_out);
  c_short: cover property (short_frame_out);
  c_byp: cover property (filter_bypass_out);
endmodule
bind daip_core daip_checker i_chk (
  .core_clk_in(core_clk_in), .rst_b_in(rst_b_in),
  .reg_wr_in(reg_wr_in), .reg_addr_in(reg_addr_in),
  .reg_data_in(reg_data_in), .left_sample_out(left_sample_out),
  .left_valid_out(left_valid_out), .right_sample_out(right_sample_out),
  .right_valid_out(right_valid_out),
  .filter_bypass_out(filter_bypass_out),
  .chain_data_out(chain_data_out), .ratio_code_out(ratio_code_out),
  .short_frame_out(short_frame_out)
);
`default_nettype wire

// File: dv/daip_source_model.sv
/*
  Audio source model: bit clock, frame clock and serial data.
  Assumes the bench calls one task at a time.
*/
`timescale 1ns/10ps
`default_nettype none
module daip_source_model (
  input wire logic inv_in,
  output logic bclk_out,
  output logic frame_out,
  output logic data_out
);
  import daip_pkg::*;
  logic raw = 1'b0;
  // Inverted clock for sources that change data on rising edges
  assign bclk_out = raw ^ inv_in;
  initial
  begin
    frame_out = 1'b0;
    data_out = 1'b0;
  end
  // Clock runs only here and in send, raw parked low otherwise
  task automatic idle(input int n);
    repeat (n)
    begin
      #3 raw = 1'b1;
      #3 raw = 1'b0;
    end
  endtask
  // One frame, s clocks per half, w bit words
  task automatic send(input logic [1:0] f, input logic b, input int s,
    input int w, input logic [31:0] l, input logic [31:0] r);
    int j;
    int p;
    int q;
    logic [31:0] v;
    for (int k = 0; k < 2 * s; k++)
    begin
      j = k % s;
      v = (k < s) ? l : r;
      q = k - (b ? 0 : 1);
      case (f)
        FMT_LJ: p = w - 1 - j;
        FMT_I2S: p = w - j;
        FMT_RJ: p = s - 1 - j;
        default:
        begin
          v = (q < w) ? l : r;
          p = (q < w) ? w - 1 - q : 2 * w - 1 - q;
        end
      endcase
      raw = 1'b0;
      // Level per half, or a one-clock pulse as frame sync
      frame_out = (f == FMT_DSP) ? (k == 0) : (k < s) ^ (f == FMT_I2S);
      // Spare slots toggle so no stale bit can pass as data
      data_out = (p >= 0 && p < w) ? v[p] : ~data_out;
      #3 raw = 1'b1;
      #3;
    end
    raw = 1'b0;
  endtask
endmodule
`default_nettype wire

// File: dv/test_dac_audio_input_port.sv
/*
  Testbench for the audio input port: framings, short frame
  override, ratio detection and bypass. Needs the source model.
*/
`timescale 1ns/10ps
`default_nettype none
module test_dac_audio_input_port;
  import daip_pkg::*;
  logic core_clk_in = 1'b0;
  logic rst_b_in = 1'b0;
  logic reg_wr_in = 1'b0;
  logic [6:0] reg_addr_in = 7'h00;
  logic [8:0] reg_data_in = 9'h000;
  logic inv = 1'b0;
  logic lf = 1'b0;
  logic rf = 1'b0;
  logic lb = 1'b0;
  logic rb = 1'b0;
  wire logic bclk;
  wire logic fclk;
  wire logic sdat;
  wire logic [31:0] ls;
  wire logic [31:0] rs;
  wire logic byp;
  wire logic lv;
  wire logic rv;
  int lcnt = 0;
  int rcnt = 0;
  wire logic [2:0] rc;
  wire logic sf;
  int seed = 42;
  int errors = 0;
  int compares = 0;
  logic [31:0] l;
  logic [31:0] r;
  // Format word, clocks per half frame, word width
  logic [8:0] cfg [10] = '{9'h00a, 9'h005, 9'h002, 9'h006, 9'h007,
    9'h00e, 9'h01d, 9'h026, 9'h008, 9'h00a};
  int sl [10] = '{32, 32, 32, 16, 32, 32, 24, 32, 80, 160};
  int ew [10] = '{24, 20, 24, 16, 32, 24, 20, 24, 16, 24};
  always #4 core_clk_in = ~core_clk_in;
  daip_source_model i_src (.inv_in(inv), .bclk_out(bclk),
    .frame_out(fclk), .data_out(sdat));
  daip_core i_dut (
    .core_clk_in(core_clk_in), .rst_b_in(rst_b_in), .bit_clk_in(bclk),
    .frame_clk_in(fclk), .serial_data_in(sdat),
    .left_fast_data_in(lf), .right_fast_data_in(rf),
    .left_bitstream_in(lb), .right_bitstream_in(rb),
    .reg_wr_in(reg_wr_in), .reg_addr_in(reg_addr_in),
    .reg_data_in(reg_data_in), .left_sample_out(ls),
    .left_valid_out(lv), .right_sample_out(rs), .right_valid_out(rv),
    .filter_bypass_out(byp), .chain_data_out(),
    .ratio_code_out(rc), .short_frame_out(sf));
  // Unused pins still toggle so stray decoding shows up
  always @(negedge core_clk_in)
    {lf, rf, lb, rb} = 4'($random(seed));
  // Count word pulses mid-cycle, away from the launching edge
  always @(negedge core_clk_in)
  begin
    if (lv)
      lcnt++;
    if (rv)
      rcnt++;
  end
  // Sample as the port should present it: MSB at bit 31
  function automatic logic [31:0] exp_s(input logic [31:0] v, input int w);
    return v << (32 - w);
  endfunction
  // Core cycles per frame at 6 ns bit clock, 8 ns core clock
  function automatic logic [2:0] rexp(input int s);
    int c;
    c = s * 3 / 2;
    if (c < 96 || c >= 896) return RATIO_NONE;
    if (c < 160) return RATIO_128;
    if (c < 224) return RATIO_192;
    if (c < 320) return RATIO_256;
    if (c < 448) return RATIO_384;
    if (c < 640) return RATIO_512;
    return RATIO_768;
  endfunction
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp)
    begin
      errors++;
      $display("[FAIL] %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [6:0] a, input logic [8:0] d);
    @(negedge core_clk_in);
    reg_wr_in = 1'b1;
    reg_addr_in = a;
    reg_data_in = d;
    @(negedge core_clk_in);
    reg_wr_in = 1'b0;
  endtask
  task automatic setchk(input logic [6:0] a, input logic [8:0] d,
    input logic e);
    wr(a, d);
    repeat (6) @(negedge core_clk_in);
    chk(32'(byp), 32'(e));
  endtask
  task automatic stop_test();
    $display("compares %0d errors %0d", compares, errors);
    if (errors == 0 && compares > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  // Watchdog well beyond the expected run length
  initial
  begin
    #300000;
    errors++;
    stop_test();
  end
  initial
  begin
    // Link side needs its own edges to take reset
    fork
      i_src.idle(5);
      repeat (4) @(negedge core_clk_in);
    join
    rst_b_in = 1'b1;
    for (int i = 0; i < 10; i++)
    begin
      if (i > 0)
        wr(FMT_CTRL_ADDR, cfg[i]);
      inv = cfg[i][EDGE_BIT];
      #1;
      lcnt = 0;
      rcnt = 0;
      l = $random(seed);
      r = $random(seed);
      // First frame may be lost while settings cross over
      repeat (3) i_src.send(cfg[i][3:2], cfg[i][POL_BIT], sl[i], ew[i], l, r);
      repeat (12) @(negedge core_clk_in);
      chk(ls, exp_s(l, ew[i]));
      chk(rs, exp_s(r, ew[i]));
      chk(32'(sf), 32'(sl[i] == 16));
      chk(32'(lcnt >= 2), 32'h1);
      chk(32'(rcnt >= 2), 32'h1);
      chk(32'(rc), 32'(rexp(sl[i])));
      $display("test %0d done", i);
    end
    for (int p = 0; p < 3; p++)
      setchk(MODE_CTRL_ADDR, 9'(p), p == 1);
    setchk(MODE_CTRL_ADDR, 9'h080, 1'b1);
    setchk(MODE_CTRL_ADDR, 9'h000, 1'b0);
    setchk(7'h7f, 9'h1ff, 1'b0);
    $display("test bypass done");
    stop_test();
  end
endmodule
`default_nettype wire
